// file: design/i2c_expander_host.sv
// Host controller for an eight-bit two-wire I/O expander.
// Assumes open-drain bus wires resolved outside; Avalon-MM slave for software.
// How it works
// - Pulling the reset pin low does the same; the host may pulse it.
// - Master begins a transfer only while the bus is idle.
// - Start is data falling while clock is high.
// - Address byte goes most significant bit first, direction bit last.
// - Address straps stay constant from Start until Stop.
// - One bit per clock pulse; data stays stable while clock is high.
// - Stop is data rising while clock is high.
// - Each byte is eight bits plus acknowledge; any number per transfer (the host moves one data byte per transfer).
// - Transmitter releases data before the acknowledge bit.
// - Receivers acknowledge each byte, master skips the final read byte.
// - Master ends a read with not-acknowledge; device then releases data.
// - Address byte low bit: one reads, zero writes.
// - First write byte is a command; two low bits select the register.
`timescale 1ns/1ps

module i2c_expander_host (
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe_out,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	output logic             dev_rst_n_out,
	input  wire logic        dev_int_n_in,
	output logic             addr_strap_lo_out,
	output logic             addr_strap_hi_out
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	i2c_host_pkg::state_t                      state;
	logic [2:0]                                s1;
	logic [2:0]                                s2;
	logic [2:0]                                s3;
	logic [2:0]                                filt;
	logic [i2c_host_pkg::QCNT_W-1:0]           qcnt;
	logic                                      qtick;
	logic [1:0]                                q;
	logic [3:0]                                bit_cnt;
	logic [1:0]                                step;
	logic [7:0]                                shreg;
	logic [7:0]                                rxd;
	logic [7:0]                                txd;
	logic [1:0]                                sel;
	logic                                      rd;
	logic [1:0]                                strap;
	logic                                      nack;
	logic                                      pend_go;
	logic                                      pend_rst;
	logic                                      rvalid;
	logic [i2c_host_pkg::RCNT_W-1:0]           rcnt;
	logic                                      scl_low;
	logic                                      sda_low;
	logic                                      scl_f;
	logic                                      sda_f;
	logic                                      bus_free;
	logic                                      busy;
	logic                                      go_take;
	logic                                      rst_take;
	logic [2:0]                                widx;
	logic [6:0]                                dev_addr;

	assign scl_f             = filt[0];
	assign sda_f             = filt[1];
	assign bus_free          = scl_f & sda_f;
	assign busy              = pend_go | (state != i2c_host_pkg::ST_IDLE);
	assign go_take           = (state == i2c_host_pkg::ST_IDLE) & pend_go & bus_free;
	assign rst_take          = (state == i2c_host_pkg::ST_IDLE) & pend_rst & ~pend_go;
	assign widx              = avs_address_in[4:2];
	assign dev_addr          = {i2c_host_pkg::DEV_ADDR_HI, strap};
	assign scl_out           = 1'b0;
	assign sda_out           = 1'b0;
	assign scl_oe_out        = scl_low;
	assign sda_oe_out        = sda_low;
	assign addr_strap_lo_out = strap[0];
	assign addr_strap_hi_out = strap[1];
	assign avs_waitrequest_out = avs_read_in & ~rvalid;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// A level counts only once stages two and three agree, so a one-cycle glitch is dropped
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s1   <= 3'h7;
			s2   <= 3'h7;
			s3   <= 3'h7;
			filt <= 3'h7;
		end else begin
			s1   <= {dev_int_n_in, sda_in, scl_in};
			s2   <= s1;
			s3   <= s2;
			filt <= (filt & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			sel      <= 2'h0;
			rd       <= 1'b0;
			txd      <= 8'h00;
			strap    <= 2'h0;
			pend_go  <= 1'b0;
			pend_rst <= 1'b0;
		end else begin
			if (go_take)
				pend_go <= 1'b0;
			if (rst_take)
				pend_rst <= 1'b0;
			// Settings only move while idle, so a transfer sees them frozen
			if (avs_write_in && !busy && !pend_rst) begin
				case (widx)
					i2c_host_pkg::REG_CTRL: begin
						sel      <= avs_writedata_in[1:0];
						rd       <= avs_writedata_in[i2c_host_pkg::CTRL_RD_BIT];
						pend_go  <= avs_writedata_in[i2c_host_pkg::CTRL_GO_BIT];
						pend_rst <= avs_writedata_in[i2c_host_pkg::CTRL_RST_BIT];
					end
					i2c_host_pkg::REG_TXD:   txd   <= avs_writedata_in[7:0];
					i2c_host_pkg::REG_STRAP: strap <= avs_writedata_in[1:0];
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rvalid           <= 1'b0;
			avs_readdata_out <= 32'h0;
		end else if (avs_read_in && !rvalid) begin
			rvalid <= 1'b1;
			case (widx)
				i2c_host_pkg::REG_CTRL:  avs_readdata_out <= {27'h0, 2'h0, rd, sel};
				i2c_host_pkg::REG_TXD:   avs_readdata_out <= {24'h0, txd};
				i2c_host_pkg::REG_RXD:   avs_readdata_out <= {24'h0, rxd};
				i2c_host_pkg::REG_STAT:  avs_readdata_out <= {29'h0, ~filt[2], nack, busy};
				i2c_host_pkg::REG_STRAP: avs_readdata_out <= {30'h0, strap};
				default:                 avs_readdata_out <= 32'h0;
			endcase
		end else begin
			rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Quarter-bit divider
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || state == i2c_host_pkg::ST_IDLE || state == i2c_host_pkg::ST_RST) begin
			qcnt  <= '0;
			qtick <= 1'b0;
		end else if (qcnt == i2c_host_pkg::QCNT_W'(i2c_host_pkg::QTR_CYC - 1)) begin
			qcnt  <= '0;
			qtick <= 1'b1;
		end else begin
			qcnt  <= qcnt + 1'b1;
			qtick <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Transfer engine
	// ----------------------------------------------------------------
	// Write: Start, address+W, command, data, Stop.
	// Read: Start, address+W, command, restart, address+R, one byte, not-ack, Stop.
	// Clock stretching is not honoured; the device never stretches.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state         <= i2c_host_pkg::ST_RST;
			rcnt          <= i2c_host_pkg::RCNT_W'(i2c_host_pkg::RST_CYC);
			dev_rst_n_out <= 1'b0;
			scl_low       <= 1'b0;
			sda_low       <= 1'b0;
			q             <= i2c_host_pkg::PH_LOW;
			bit_cnt       <= 4'h0;
			step          <= i2c_host_pkg::STEP_ADDR;
			shreg         <= 8'h00;
			rxd           <= 8'h00;
			nack          <= 1'b0;
		end else begin
			if (qtick)
				q <= q + 1'b1;
			case (state)
				i2c_host_pkg::ST_RST: begin
					if (rcnt == '0) begin
						dev_rst_n_out <= 1'b1;
						state         <= i2c_host_pkg::ST_IDLE;
					end else begin
						rcnt <= rcnt - 1'b1;
					end
				end
				i2c_host_pkg::ST_IDLE: begin
					q <= i2c_host_pkg::PH_LOW;
					if (go_take) begin
						state <= i2c_host_pkg::ST_START;
						step  <= i2c_host_pkg::STEP_ADDR;
						nack  <= 1'b0;
					end else if (rst_take) begin
						state         <= i2c_host_pkg::ST_RST;
						rcnt          <= i2c_host_pkg::RCNT_W'(i2c_host_pkg::RST_CYC);
						dev_rst_n_out <= 1'b0;
					end
				end
				i2c_host_pkg::ST_START: if (qtick) begin
					case (q)
						i2c_host_pkg::PH_LOW:  scl_low <= (step != i2c_host_pkg::STEP_ADDR);
						i2c_host_pkg::PH_SET:  sda_low <= 1'b0;
						i2c_host_pkg::PH_RISE: scl_low <= 1'b0;
						default: begin
							sda_low <= 1'b1;
							state   <= i2c_host_pkg::ST_SEND;
							bit_cnt <= 4'h0;
							// Address first, direction last; restart only precedes a read
							shreg   <= {dev_addr, step != i2c_host_pkg::STEP_ADDR};
						end
					endcase
				end
				i2c_host_pkg::ST_SEND: if (qtick) begin
					case (q)
						i2c_host_pkg::PH_LOW:  scl_low <= 1'b1;
						// Released for the acknowledge bit so the device can pull low
						i2c_host_pkg::PH_SET:
							sda_low <= (bit_cnt == i2c_host_pkg::ACK_BIT) ? 1'b0 : ~shreg[7];
						i2c_host_pkg::PH_RISE: scl_low <= 1'b0;
						default: begin
							if (bit_cnt != i2c_host_pkg::ACK_BIT) begin
								shreg   <= {shreg[6:0], 1'b0};
								bit_cnt <= bit_cnt + 1'b1;
							end else begin
								bit_cnt <= 4'h0;
								if (sda_f) begin
									nack  <= 1'b1;
									state <= i2c_host_pkg::ST_STOP;
								end else begin
									case (step)
										i2c_host_pkg::STEP_ADDR: begin
											step  <= i2c_host_pkg::STEP_CMD;
											shreg <= {6'h00, sel};
										end
										i2c_host_pkg::STEP_CMD: begin
											step  <= i2c_host_pkg::STEP_DATA;
											shreg <= txd;
											if (rd)
												state <= i2c_host_pkg::ST_START;
										end
										default: begin
											if (rd) begin
												step  <= i2c_host_pkg::STEP_RX;
												state <= i2c_host_pkg::ST_RECV;
											end else begin
												state <= i2c_host_pkg::ST_STOP;
											end
										end
									endcase
								end
							end
						end
					endcase
				end
				i2c_host_pkg::ST_RECV: if (qtick) begin
					case (q)
						i2c_host_pkg::PH_LOW:  scl_low <= 1'b1;
						// Single-byte read: the acknowledge slot is a not-acknowledge
						i2c_host_pkg::PH_SET:  sda_low <= 1'b0;
						i2c_host_pkg::PH_RISE: scl_low <= 1'b0;
						default: begin
							if (bit_cnt != i2c_host_pkg::ACK_BIT) begin
								shreg   <= {shreg[6:0], sda_f};
								bit_cnt <= bit_cnt + 1'b1;
							end else begin
								bit_cnt <= 4'h0;
								rxd     <= shreg;
								state   <= i2c_host_pkg::ST_STOP;
							end
						end
					endcase
				end
				i2c_host_pkg::ST_STOP: if (qtick) begin
					case (q)
						i2c_host_pkg::PH_LOW:  scl_low <= 1'b1;
						i2c_host_pkg::PH_SET:  sda_low <= 1'b1;
						i2c_host_pkg::PH_RISE: scl_low <= 1'b0;
						default: begin
							sda_low <= 1'b0;
							state   <= i2c_host_pkg::ST_IDLE;
						end
					endcase
				end
				default: state <= i2c_host_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_start_shape;
		@(posedge clk_in) disable iff (sys_rst_in)
		($rose(sda_low) && !scl_low) |-> $past(state) == i2c_host_pkg::ST_START;
	endproperty
	a_start_shape: assert property (p_start_shape)
		else $error("data fell with clock high outside a start");

	property p_stop_shape;
		@(posedge clk_in) disable iff (sys_rst_in)
		($fell(sda_low) && !scl_low) |-> $past(state) == i2c_host_pkg::ST_STOP;
	endproperty
	a_stop_shape: assert property (p_stop_shape)
		else $error("data rose with clock high outside a stop");

	property p_data_stable;
		@(posedge clk_in) disable iff (sys_rst_in)
		($past(state) == i2c_host_pkg::ST_SEND && state == i2c_host_pkg::ST_SEND
			&& !scl_low && !$past(scl_low)) |-> $stable(sda_low);
	endproperty
	a_data_stable: assert property (p_data_stable)
		else $error("data moved while clock high during a byte");

	property p_msb_first;
		@(posedge clk_in) disable iff (sys_rst_in)
		(state == i2c_host_pkg::ST_SEND && q == i2c_host_pkg::PH_RISE
			&& bit_cnt != i2c_host_pkg::ACK_BIT) |-> sda_low == !shreg[7];
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("sent bit is not the top of the shift register");

	property p_ack_release;
		@(posedge clk_in) disable iff (sys_rst_in)
		(state == i2c_host_pkg::ST_SEND && bit_cnt == i2c_host_pkg::ACK_BIT
			&& (q == i2c_host_pkg::PH_RISE || q == i2c_host_pkg::PH_SAMPLE)) |-> !sda_low;
	endproperty
	a_ack_release: assert property (p_ack_release)
		else $error("data held during the acknowledge bit");

	property p_read_nack;
		@(posedge clk_in) disable iff (sys_rst_in)
		(state == i2c_host_pkg::ST_RECV && $past(state) == i2c_host_pkg::ST_RECV)
			|-> !sda_low;
	endproperty
	a_read_nack: assert property (p_read_nack)
		else $error("host drove data while receiving");

	property p_idle_begin;
		@(posedge clk_in) disable iff (sys_rst_in)
		($past(state) == i2c_host_pkg::ST_IDLE && state == i2c_host_pkg::ST_START)
			|-> $past(bus_free);
	endproperty
	a_idle_begin: assert property (p_idle_begin)
		else $error("transfer began on a busy bus");

	property p_rst_pulse;
		@(posedge clk_in) disable iff (sys_rst_in)
		($past(state) == i2c_host_pkg::ST_IDLE && state == i2c_host_pkg::ST_RST)
			|-> !dev_rst_n_out [*8];
	endproperty
	a_rst_pulse: assert property (p_rst_pulse)
		else $error("device reset pulse too short");

	property p_strap_hold;
		@(posedge clk_in) disable iff (sys_rst_in)
		(state != i2c_host_pkg::ST_IDLE && $past(state) != i2c_host_pkg::ST_IDLE)
			|-> $stable(strap);
	endproperty
	a_strap_hold: assert property (p_strap_hold)
		else $error("address strap changed during a transfer");

endmodule // i2c_expander_host

// file: design/i2c_host_pkg.sv
// Constants, register map and states for the two-wire expander host.
// Assumes a 10 MHz system clock and a single-byte transfer engine.
package i2c_host_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned BIT_NS        = 10_000;
	// Quarter of a bit time; longest time, rounds down
	localparam int unsigned QTR_CYC       = BIT_NS / 4 / CLK_PERIOD_NS;
	// Reset pulse on the device pin; least time, rounds up
	localparam int unsigned RST_NS        = 1_000;
	localparam int unsigned RST_CYC       = (RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned QCNT_W        = 5;
	localparam int unsigned RCNT_W        = 4;

	// ----------------------------------------------------------------
	// Serial protocol
	// ----------------------------------------------------------------
	localparam logic [4:0] DEV_ADDR_HI   = 5'h1c;
	localparam logic [3:0] ACK_BIT       = 4'h8;
	localparam logic [1:0] PH_LOW        = 2'h0;
	localparam logic [1:0] PH_SET        = 2'h1;
	localparam logic [1:0] PH_RISE       = 2'h2;
	localparam logic [1:0] PH_SAMPLE     = 2'h3;
	localparam logic [1:0] STEP_ADDR     = 2'h0;
	localparam logic [1:0] STEP_CMD      = 2'h1;
	localparam logic [1:0] STEP_DATA     = 2'h2;
	localparam logic [1:0] STEP_RX       = 2'h3;

	// ----------------------------------------------------------------
	// Software registers (word index, byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam logic [2:0] REG_CTRL      = 3'h0;
	localparam logic [2:0] REG_TXD       = 3'h1;
	localparam logic [2:0] REG_RXD       = 3'h2;
	localparam logic [2:0] REG_STAT      = 3'h3;
	localparam logic [2:0] REG_STRAP     = 3'h4;
	localparam int unsigned CTRL_RD_BIT  = 2;
	localparam int unsigned CTRL_GO_BIT  = 3;
	localparam int unsigned CTRL_RST_BIT = 4;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_START = 3'h1,
		ST_SEND  = 3'h3,
		ST_RECV  = 3'h2,
		ST_STOP  = 3'h6,
		ST_RST   = 3'h7
	} state_t;

endpackage

// file: tb/expander_model.sv
// Behavioural model of the eight-bit two-wire I/O expander.
// Assumes resolved bus wires with pull-ups; the bench merges the drivers.
`timescale 1ns/1ps

module expander_model (
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_oe_out,
	input  wire logic       rst_n_in,
	output logic            int_n_out,
	input  wire logic       addr_strap_lo_in,
	input  wire logic       addr_strap_hi_in,
	input  wire logic [7:0] pin_level_in,
	output logic      [7:0] high_side_driver_out,
	output logic      [7:0] low_side_driver_out
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam logic [6:0] BASE_ADDR = 7'h70;
	localparam logic [2:0] M_IDLE    = 3'h0;
	localparam logic [2:0] M_ADDR    = 3'h1;
	localparam logic [2:0] M_CMD     = 3'h2;
	localparam logic [2:0] M_WR      = 3'h3;
	localparam logic [2:0] M_RD      = 3'h4;
	logic [7:0] cfg, outr, pol, snap, shift, tx, pins;
	logic [1:0] ptr;
	logic [2:0] mode;
	logic [3:0] cnt;

	assign pins = (cfg & pin_level_in) | (~cfg & outr);
	assign high_side_driver_out = ~cfg & outr;
	assign low_side_driver_out  = ~cfg & ~outr;
	// Outputs never raise it: masked by direction
	assign int_n_out = ~|((pins ^ snap) & cfg);

	function automatic logic [7:0] reg_val(input logic [1:0] p);
		case (p)
			2'h0: return pins ^ pol;
			2'h1: return outr;
			2'h2: return pol;
			default: return cfg;
		endcase
	endfunction

	task automatic set_defaults();
		cfg = 8'hff;
		outr = 8'hff;
		pol = 8'h00;
		ptr = 2'h0;
		mode = M_IDLE;
		cnt = 4'h0;
		sda_oe_out = 1'b0;
		snap = pin_level_in;
	endtask

	initial set_defaults();
	always @(negedge rst_n_in) set_defaults();

	// ----------------------------------------------------------------
	// Bus conditions and bits
	// ----------------------------------------------------------------
	always @(negedge sda_in) if (rst_n_in && scl_in) begin
		mode = M_ADDR;
		cnt = 4'hf;
	end

	always @(posedge sda_in) if (rst_n_in && scl_in) begin
		mode = M_IDLE;
		sda_oe_out = 1'b0;
		snap = pins;
	end

	// Bench wires are ideal, so no glitch filter or synchroniser here
	always @(posedge scl_in) if (rst_n_in && mode != M_IDLE) begin
		if (cnt < 4'h8)
			shift = {shift[6:0], sda_in};
		else if (cnt == 4'h8 && mode == M_RD && sda_in)
			mode = M_IDLE;
	end

	always @(negedge scl_in) if (rst_n_in && mode != M_IDLE) begin
		if (cnt == 4'hf) begin
			cnt = 4'h0;
		end else if (cnt == 4'h7) begin
			cnt = 4'h8;
			sda_oe_out = 1'b0;
			case (mode)
				M_ADDR: if (shift[7:1] == BASE_ADDR + {addr_strap_hi_in, addr_strap_lo_in}) begin
					sda_oe_out = 1'b1;
					if (shift[0]) begin
						mode = M_RD;
						tx = reg_val(ptr);
						if (ptr == 2'h0) snap = pins;
					end
				end else begin
					mode = M_IDLE;
				end
				M_CMD: begin
					ptr = shift[1:0];
					sda_oe_out = 1'b1;
				end
				M_WR: begin
					case (ptr)
						2'h1: outr = shift;
						2'h2: pol = shift;
						2'h3: cfg = shift;
						default: ;
					endcase
					sda_oe_out = 1'b1;
				end
				default: ;
			endcase
		end else if (cnt == 4'h8) begin
			cnt = 4'h0;
			sda_oe_out = 1'b0;
			if (mode == M_ADDR) mode = M_CMD;
			else if (mode == M_CMD) mode = M_WR;
			if (mode == M_RD) begin
				tx = reg_val(ptr);
				sda_oe_out = ~tx[7];
			end
		end else begin
			cnt = cnt + 4'h1;
			if (mode == M_RD) sda_oe_out = ~tx[3'(4'h7 - cnt)];
		end
	end

endmodule // expander_model

// file: tb/tb_top.sv
// Self-checking bench for the expander host, with a device model.
// Assumes pull-ups on both bus wires and on the interrupt line.
`timescale 1ns/1ps

module tb_top;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	typedef struct packed {logic [31:0] val; logic [31:0] mask;} exp_t;
	logic        clk_in = 1'b0;
	logic        sys_rst_in;
	logic [4:0]  avs_address_in;
	logic        avs_read_in, avs_write_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, seen;
	logic        avs_waitrequest_out, seen_v;
	logic        scl_out, scl_oe_out, sda_out, sda_oe_out, dev_sda_oe;
	logic        dev_rst_n_out, dev_int_n, strap_lo, strap_hi, strap_flip;
	logic        scl_line, sda_line;
	logic [7:0]  pin_level;
	int          failures, checks, low_cnt;
	integer      seed;
	exp_t        exp_q[$];

	always #50 clk_in = ~clk_in;
	assign scl_line = ~scl_oe_out;
	assign sda_line = ~(sda_oe_out | dev_sda_oe);

	i2c_expander_host u_i2c_expander_host (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .scl_in(scl_line), .scl_out(scl_out),
		.scl_oe_out(scl_oe_out), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe_out(sda_oe_out), .dev_rst_n_out(dev_rst_n_out), .dev_int_n_in(dev_int_n),
		.addr_strap_lo_out(strap_lo), .addr_strap_hi_out(strap_hi));

	expander_model u_expander_model (
		.scl_in(scl_line), .sda_in(sda_line), .sda_oe_out(dev_sda_oe),
		.rst_n_in(dev_rst_n_out), .int_n_out(dev_int_n),
		.addr_strap_lo_in(strap_lo ^ strap_flip), .addr_strap_hi_in(strap_hi),
		.pin_level_in(pin_level), .high_side_driver_out(), .low_side_driver_out());

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] want);
		checks++;
		if (got !== want) begin
			failures++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, got, want);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= ~wr;
		do begin
			@(posedge clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 20);
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		if (n >= 20) failures++;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd_expect(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] q;
		exp_q.push_back({e, m});
		bus(1'b0, a, 32'h0, q);
		seen <= q;
		seen_v <= 1'b1;
		@(posedge clk_in);
		seen_v <= 1'b0;
	endtask

	// Go, then poll status until the engine has been busy and is idle again
	task automatic xfer(input logic rd, input logic [1:0] sel, input logic [7:0] d);
		logic [31:0] q;
		int n;
		wr(5'h04, {24'h0, d});
		wr(5'h00, {27'h0, 1'b1, rd, sel});
		n = 0;
		do begin
			bus(1'b0, 5'h0c, 32'h0, q);
			n++;
		end while (q[0] !== 1'b1 && n < 8);
		if (n >= 8) failures++;
		n = 0;
		do begin
			repeat (50) @(posedge clk_in);
			bus(1'b0, 5'h0c, 32'h0, q);
			n++;
		end while (q[0] !== 1'b0 && n < 200);
		if (n >= 200) failures++;
	endtask

	task automatic reg_rd(input logic [1:0] sel, input logic [7:0] e);
		xfer(1'b1, sel, 8'h00);
		rd_expect(5'h08, {24'h0, e}, 32'h0000_00ff);
	endtask

	// ----------------------------------------------------------------
	// Monitors
	// ----------------------------------------------------------------
	always @(posedge clk_in) if (seen_v) begin
		exp_t e;
		e = exp_q.pop_front();
		check(seen & e.mask, e.val);
	end

	always @(posedge clk_in) if (dev_rst_n_out === 1'b0) low_cnt <= low_cnt + 1;

	initial begin
		repeat (100000) @(posedge clk_in);
		failures++;
		finish_test();
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] v, p, e8;
		int lc;
		seed = 32'hf3db;
		sys_rst_in = 1'b1;
		avs_address_in = 5'h0;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_writedata_in = 32'h0;
		seen = 32'h0;
		seen_v = 1'b0;
		strap_flip = 1'b0;
		pin_level = 8'h3c;
		failures = 0;
		checks = 0;
		low_cnt = 0;
		repeat (5) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		repeat (20) @(posedge clk_in);
		reg_rd(2'h3, 8'hff);
		reg_rd(2'h1, 8'hff);
		// Straps only change between transfers
		for (int i = 0; i < 4; i++) begin
			wr(5'h10, 32'(i));
			p = 8'($random(seed));
			xfer(1'b0, 2'h2, p);
			reg_rd(2'h2, p);
			rd_expect(5'h0c, 32'h0, 32'h2);
		end
		strap_flip <= 1'b1;
		xfer(1'b0, 2'h1, 8'h00);
		rd_expect(5'h0c, 32'h2, 32'h2);
		strap_flip <= 1'b0;
		reg_rd(2'h1, 8'hff);
		v = 8'($random(seed));
		e8 = 8'($random(seed));
		pin_level <= e8;
		xfer(1'b0, 2'h3, 8'h0f);
		xfer(1'b0, 2'h1, v);
		reg_rd(2'h0, {v[7:4], e8[3:0]} ^ p);
		xfer(1'b0, 2'h3, 8'hff);
		pin_level <= e8 ^ 8'h10;
		repeat (10) @(posedge clk_in);
		rd_expect(5'h0c, 32'h4, 32'h4);
		reg_rd(2'h0, (e8 ^ 8'h10) ^ p);
		rd_expect(5'h0c, 32'h0, 32'h4);
		lc = low_cnt;
		xfer(1'b0, 2'h3, 8'h00);
		wr(5'h00, 32'h10);
		repeat (30) @(posedge clk_in);
		check(32'(low_cnt > lc), 32'h1);
		reg_rd(2'h3, 8'hff);
		xfer(1'b0, 2'h1, 8'h5a);
		sys_rst_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		repeat (20) @(posedge clk_in);
		reg_rd(2'h1, 8'hff);
		wr(5'h14, 32'hffff_ffff);
		rd_expect(5'h14, 32'h0, 32'hffff_ffff);
		finish_test();
	end

endmodule // tb_top
